// ==== pkg/ghr_pkg.sv ====
// constants and helpers for the gyro high-rate and drift cancel block
// Functional notes
// [R01] alarm level and hysteresis decode as (255 + 256*n) * 4 rate LSB
// [R02] level register: hysteresis 7:6, level 5:1, enable 0; level resets 1
// [R03] alarm evaluated only for axes with enable bit set, one per axis
// [R04] 8-bit persist code m gives dwell (1 + m) * 2.5 ms; resets 0x19
// [R05] alarm level and hysteresis are rate LSB, so scale with range
// [R06] drift cancel level code 7:6 is 0.1, 0.2, 0.5, 1 deg/s
// [R07] drift cancel time code 5:3 is 40 to 1280 ms; 6, 7 unused
// [R08] drift cancel runs only on axes enabled in bits 0..2, reset zero
// [R09] drift cancel setup resets to level 1, time 4, axes off
// [R10] alarm uses unfiltered rate when its source bit is one
// [R11] drift cancel uses unfiltered rate when its source bit is one
// [R12] alarm sets after dwell above level, clears below level minus hyst
// [R13] drift cancel steps offset when rate stays under level for time
package ghr_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int ALARM_TICK_US = 2500;
    localparam int ALARM_TICK_CYC = ALARM_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int DRIFT_TICK_US = 40000;
    localparam int DRIFT_TICK_CYC = DRIFT_TICK_US * 1000 / CLK_PERIOD_NS;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [7:0] ADDR_LEVEL_X = 8'h22;
    localparam logic [7:0] ADDR_PERSIST_X = 8'h23;
    localparam logic [7:0] ADDR_LEVEL_Y = 8'h24;
    localparam logic [7:0] ADDR_PERSIST_Y = 8'h25;
    localparam logic [7:0] ADDR_LEVEL_Z = 8'h26;
    localparam logic [7:0] ADDR_PERSIST_Z = 8'h27;
    localparam logic [7:0] ADDR_DRIFT = 8'h31;
    localparam int HYST_LSB = 6;
    localparam int LEVEL_LSB = 1;
    localparam int ALARM_EN_BIT = 0;
    localparam int DRIFT_LEVEL_LSB = 6;
    localparam int DRIFT_TIME_LSB = 3;
    localparam logic [7:0] LEVEL_RST = 8'h02;
    localparam logic [7:0] PERSIST_RST = 8'h19;
    localparam logic [7:0] DRIFT_RST = 8'h60;

    // ************************************************************
    // scaling
    // ************************************************************
    localparam logic [16:0] ALARM_BASE = 17'h003fc;
    localparam logic [2:0] DRIFT_TIME_MAX = 3'h5;
    localparam logic [2:0] RANGE_FINEST = 3'h4;
    // drift levels in LSB at the finest range; coarser ranges shift right
    localparam logic [16:0] DRIFT_LSB_0 = 17'h0001a;
    localparam logic [16:0] DRIFT_LSB_1 = 17'h00034;
    localparam logic [16:0] DRIFT_LSB_2 = 17'h00083;
    localparam logic [16:0] DRIFT_LSB_3 = 17'h00106;

    function automatic logic [16:0] alarm_lsb(input logic [4:0] n);
        return ALARM_BASE + 17'({n, 10'h000});
    endfunction : alarm_lsb

    function automatic logic [16:0] magnitude(input logic [15:0] v);
        logic [16:0] w;
        w = {v[15], v};
        return w[16] ? 17'(-w) : w;
    endfunction : magnitude

    function automatic logic [16:0] drift_lsb(input logic [1:0] code,
                                              input logic [2:0] range);
        logic [16:0] base;
        logic [2:0] r;
        r = (range > RANGE_FINEST) ? RANGE_FINEST : range;
        case (code)
            2'h0: base = DRIFT_LSB_0;
            2'h1: base = DRIFT_LSB_1;
            2'h2: base = DRIFT_LSB_2;
            default: base = DRIFT_LSB_3;
        endcase
        return base >> (RANGE_FINEST - r);
    endfunction : drift_lsb
endpackage : ghr_pkg

// ==== pkg/ghr_axis_if.sv ====
// per-axis settings and results between the register bank and an axis
`timescale 1ns/100ps
interface ghr_axis_if;
    logic [15:0] rate_alarm;
    logic [15:0] rate_drift;
    logic [16:0] level;
    logic [16:0] hyst;
    logic [7:0] persist;
    logic alarm_en;
    logic [16:0] drift_level;
    logic [2:0] drift_time;
    logic drift_en;
    logic alarm_tick;
    logic drift_tick;
    logic alarm;
    logic step;
    logic step_neg;
    modport bank (output rate_alarm, rate_drift, level, hyst, persist,
                  alarm_en, drift_level, drift_time, drift_en, alarm_tick,
                  drift_tick, input alarm, step, step_neg);
    modport axis (input rate_alarm, rate_drift, level, hyst, persist,
                  alarm_en, drift_level, drift_time, drift_en, alarm_tick,
                  drift_tick, output alarm, step, step_neg);
endinterface : ghr_axis_if

// ==== rtl/ghr_axis.sv ====
// one axis: high-rate alarm with dwell and hysteresis, drift cancel steps
`timescale 1ns/100ps
module ghr_axis (
    input wire logic clock,
    input wire logic resetn,
    ghr_axis_if.axis a
);
    logic [8:0] dwell_q, dwell_d;
    logic alarm_q, alarm_d;
    logic [5:0] calm_q, calm_d;
    logic step_q, step_d;
    logic neg_q, neg_d;
    logic [16:0] mag_a, mag_d, floor_lvl;
    logic [8:0] need_a;
    logic [5:0] need_d;
    logic [2:0] time_c;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        mag_a = ghr_pkg::magnitude(a.rate_alarm);
        mag_d = ghr_pkg::magnitude(a.rate_drift);
        // a hysteresis at or above the level would leave no clear point
        floor_lvl = (a.level > a.hyst) ? a.level - a.hyst : 17'h00000; // R12
        need_a = 9'({1'b0, a.persist}) + 9'h001; // R04
        time_c = (a.drift_time > ghr_pkg::DRIFT_TIME_MAX) ?
                 ghr_pkg::DRIFT_TIME_MAX : a.drift_time; // R07
        need_d = 6'h01 << time_c; // R07
        dwell_d = dwell_q;
        alarm_d = alarm_q;
        if (!a.alarm_en) begin // R03
            dwell_d = 9'h000;
            alarm_d = 1'b0;
        end else if (alarm_q) begin
            dwell_d = 9'h000;
            alarm_d = !(mag_a < floor_lvl); // R12
        end else if (mag_a > a.level) begin // R12
            // dwell is counted in whole ticks; the first may be partial
            if (a.alarm_tick) begin
                dwell_d = dwell_q + 9'h001;
                if (dwell_d >= need_a) begin // R04
                    alarm_d = 1'b1;
                    dwell_d = 9'h000;
                end
            end
        end else begin
            dwell_d = 9'h000;
        end
        calm_d = calm_q;
        step_d = 1'b0;
        neg_d = neg_q;
        if (!a.drift_en || mag_d >= a.drift_level) begin // R08 R13
            calm_d = 6'h00;
        end else if (a.drift_tick) begin
            calm_d = calm_q + 6'h01;
            if (calm_d >= need_d) begin // R13
                calm_d = 6'h00;
                step_d = (a.rate_drift != 16'h0000);
                neg_d = a.rate_drift[15];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dwell_q <= 9'h000;
            alarm_q <= 1'b0;
            calm_q <= 6'h00;
            step_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            dwell_q <= dwell_d;
            alarm_q <= alarm_d;
            calm_q <= calm_d;
            step_q <= step_d;
            neg_q <= neg_d;
        end
    end

    assign a.alarm = alarm_q;
    assign a.step = step_q;
    assign a.step_neg = neg_q;

    // ************************************************************
    // checks
    // ************************************************************
    sequence over_level_s;
        a.alarm_en && mag_a > a.level;
    endsequence

    alarm_off_a: assert property (@(posedge clock) disable iff (!resetn) // R03
        !a.alarm_en |=> !alarm_q)
        else $error("alarm set on a disabled axis");
    alarm_cause_a: assert property ( // R12
        @(posedge clock) disable iff (!resetn)
        $rose(alarm_q) |-> $past(mag_a > a.level && a.alarm_tick))
        else $error("alarm rose without rate above level");
    alarm_clear_a: assert property ( // R12
        @(posedge clock) disable iff (!resetn)
        alarm_q && a.alarm_en && mag_a < floor_lvl |=> !alarm_q)
        else $error("alarm did not clear below hysteresis floor");
    alarm_dwell_a: assert property ( // R04
        @(posedge clock) disable iff (!resetn)
        over_level_s ##0 !alarm_q ##0 (dwell_q == 9'h000) ##0 a.alarm_tick
        ##1 (a.persist != 8'h00) |-> !alarm_q)
        else $error("alarm set before the dwell ran out");
    drift_off_a: assert property (@(posedge clock) disable iff (!resetn) // R08
        !a.drift_en |=> !step_q)
        else $error("drift step on a disabled axis");
    drift_cause_a: assert property ( // R13
        @(posedge clock) disable iff (!resetn)
        step_q |-> $past(mag_d < a.drift_level && a.drift_tick))
        else $error("drift step without calm rate");
    drift_pulse_a: assert property ( // R13
        @(posedge clock) disable iff (!resetn)
        step_q |=> !step_q)
        else $error("drift step longer than one cycle");
endmodule : ghr_axis

// ==== rtl/ghr_top.sv ====
// gyro high-rate alarm and drift cancel register bank with three axes
`timescale 1ns/100ps
module ghr_top #(
    parameter int ALARM_TICK_CYC = ghr_pkg::ALARM_TICK_CYC,
    parameter int DRIFT_TICK_CYC = ghr_pkg::DRIFT_TICK_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [2:0][15:0] rate_filt,
    input wire logic [2:0][15:0] rate_unfilt,
    input wire logic alarm_src_unfilt,
    input wire logic drift_src_unfilt,
    input wire logic [2:0] range_sel,
    output logic [2:0] high_alarm,
    output logic [2:0] drift_step,
    output logic [2:0] drift_step_neg
);
    localparam int AW = $clog2(ALARM_TICK_CYC + 1);
    localparam int DW = $clog2(DRIFT_TICK_CYC + 1);

    if (ALARM_TICK_CYC < 1 || DRIFT_TICK_CYC < 1) begin : g_chk
        $error("tick lengths must be at least one cycle");
    end

    logic [2:0][7:0] level_q, level_d;
    logic [2:0][7:0] persist_q, persist_d;
    logic [7:0] drift_q, drift_d;
    logic [7:0] rdata_q, rdata_d;
    logic [AW-1:0] atick_cnt_q, atick_cnt_d;
    logic [DW-1:0] dtick_cnt_q, dtick_cnt_d;
    logic atick_q, atick_d;
    logic dtick_q, dtick_d;

    // ************************************************************
    // register bank
    // ************************************************************
    always_comb begin
        level_d = level_q;
        persist_d = persist_q;
        drift_d = drift_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                ghr_pkg::ADDR_LEVEL_X: level_d[0] = reg_wdata; // R02
                ghr_pkg::ADDR_LEVEL_Y: level_d[1] = reg_wdata; // R02
                ghr_pkg::ADDR_LEVEL_Z: level_d[2] = reg_wdata; // R02
                ghr_pkg::ADDR_PERSIST_X: persist_d[0] = reg_wdata; // R04
                ghr_pkg::ADDR_PERSIST_Y: persist_d[1] = reg_wdata; // R04
                ghr_pkg::ADDR_PERSIST_Z: persist_d[2] = reg_wdata; // R04
                ghr_pkg::ADDR_DRIFT: drift_d = reg_wdata; // R09
                default: ;
            endcase
        end
        if (reg_rd) begin
            // writes in the same cycle are not seen by the read
            case (reg_addr)
                ghr_pkg::ADDR_LEVEL_X: rdata_d = level_q[0];
                ghr_pkg::ADDR_LEVEL_Y: rdata_d = level_q[1];
                ghr_pkg::ADDR_LEVEL_Z: rdata_d = level_q[2];
                ghr_pkg::ADDR_PERSIST_X: rdata_d = persist_q[0];
                ghr_pkg::ADDR_PERSIST_Y: rdata_d = persist_q[1];
                ghr_pkg::ADDR_PERSIST_Z: rdata_d = persist_q[2];
                ghr_pkg::ADDR_DRIFT: rdata_d = drift_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_q <= {3{ghr_pkg::LEVEL_RST}}; // R02
            persist_q <= {3{ghr_pkg::PERSIST_RST}}; // R04
            drift_q <= ghr_pkg::DRIFT_RST; // R09
            rdata_q <= 8'h00;
        end else begin
            level_q <= level_d;
            persist_q <= persist_d;
            drift_q <= drift_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ************************************************************
    // time bases
    // ************************************************************
    always_comb begin
        atick_d = (atick_cnt_q == AW'(ALARM_TICK_CYC - 1));
        atick_cnt_d = atick_d ? '0 : atick_cnt_q + AW'(1);
        dtick_d = (dtick_cnt_q == DW'(DRIFT_TICK_CYC - 1));
        dtick_cnt_d = dtick_d ? '0 : dtick_cnt_q + DW'(1);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            atick_cnt_q <= '0;
            dtick_cnt_q <= '0;
            atick_q <= 1'b0;
            dtick_q <= 1'b0;
        end else begin
            atick_cnt_q <= atick_cnt_d;
            dtick_cnt_q <= dtick_cnt_d;
            atick_q <= atick_d;
            dtick_q <= dtick_d;
        end
    end

    // ************************************************************
    // axes
    // ************************************************************
    ghr_axis_if ax_if[3] ();

    for (genvar i = 0; i < 3; i++) begin : g_axis
        // levels are in rate LSB and so follow the range without rescaling
        assign ax_if[i].level =
            ghr_pkg::alarm_lsb(level_q[i][5:ghr_pkg::LEVEL_LSB]); // R01 R05
        assign ax_if[i].hyst =
            ghr_pkg::alarm_lsb({3'h0, level_q[i][7:ghr_pkg::HYST_LSB]}); // R01
        assign ax_if[i].alarm_en = level_q[i][ghr_pkg::ALARM_EN_BIT]; // R03
        assign ax_if[i].persist = persist_q[i];
        assign ax_if[i].rate_alarm =
            alarm_src_unfilt ? rate_unfilt[i] : rate_filt[i]; // R10
        assign ax_if[i].rate_drift =
            drift_src_unfilt ? rate_unfilt[i] : rate_filt[i]; // R11
        assign ax_if[i].drift_level = ghr_pkg::drift_lsb(
            drift_q[7:ghr_pkg::DRIFT_LEVEL_LSB], range_sel); // R06
        assign ax_if[i].drift_time = drift_q[5:ghr_pkg::DRIFT_TIME_LSB]; // R07
        assign ax_if[i].drift_en = drift_q[i]; // R08
        assign ax_if[i].alarm_tick = atick_q;
        assign ax_if[i].drift_tick = dtick_q;
        assign high_alarm[i] = ax_if[i].alarm;
        assign drift_step[i] = ax_if[i].step;
        assign drift_step_neg[i] = ax_if[i].step_neg;

        ghr_axis u_axis (
            .clock(clock),
            .resetn(resetn),
            .a(ax_if[i])
        );
    end

    // ************************************************************
    // checks
    // ************************************************************
    level_write_a: assert property ( // R02
        @(posedge clock) disable iff (!resetn)
        reg_wr && reg_addr == ghr_pkg::ADDR_LEVEL_Y
        |=> level_q[1] == $past(reg_wdata))
        else $error("level register did not take the write");
    persist_read_a: assert property ( // R04
        @(posedge clock) disable iff (!resetn)
        reg_rd && !reg_wr && reg_addr == ghr_pkg::ADDR_PERSIST_Z
        |=> reg_rdata == persist_q[2])
        else $error("persist readback mismatch");
    drift_reset_a: assert property (@(posedge clock) // R09
        $rose(resetn) |-> drift_q == ghr_pkg::DRIFT_RST)
        else $error("drift setup wrong after reset");
    unmapped_a: assert property (@(posedge clock) disable iff (!resetn)
        reg_rd && reg_addr == 8'h28 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    alarm_src_a: assert property (@(posedge clock) disable iff (!resetn) // R10
        level_q[0][0] && !high_alarm[0] && alarm_src_unfilt
        && ghr_pkg::magnitude(rate_unfilt[0]) <= ax_if[0].level
        |=> !high_alarm[0])
        else $error("alarm rose from the unselected source");

    // ************************************************************
    // register checks
    // ************************************************************
    persist_write_a: assert property ( // R04
        @(posedge clock) disable iff (!resetn)
        reg_wr && reg_addr == ghr_pkg::ADDR_PERSIST_X
        |=> persist_q[0] == $past(reg_wdata))
        else $error("persist register did not take the write");
    drift_write_a: assert property ( // R09
        @(posedge clock) disable iff (!resetn)
        reg_wr && reg_addr == ghr_pkg::ADDR_DRIFT
        |=> drift_q == $past(reg_wdata))
        else $error("drift setup did not take the write");
    // an unmapped write must leave every register alone
    unmapped_wr_a: assert property (@(posedge clock) disable iff (!resetn)
        reg_wr && reg_addr == 8'h28
        |=> $stable(level_q) && $stable(persist_q) && $stable(drift_q))
        else $error("unmapped write changed a register");
    rdata_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    level_reset_a: assert property (@(posedge clock) // R02
        $rose(resetn) |-> level_q == {3{ghr_pkg::LEVEL_RST}})
        else $error("level registers wrong after reset");
    persist_reset_a: assert property (@(posedge clock) // R04
        $rose(resetn) |-> persist_q == {3{ghr_pkg::PERSIST_RST}})
        else $error("persist registers wrong after reset");
    // decode checked apart from the package function, so a slip there shows
    level_decode_a: assert property (@(posedge clock) // R01
        ax_if[2].level ==
        17'(32'h3fc + 32'h400 * 32'(level_q[2][5:ghr_pkg::LEVEL_LSB])))
        else $error("alarm level decode wrong");
    hyst_decode_a: assert property (@(posedge clock) // R01
        ax_if[1].hyst ==
        17'(32'h3fc + 32'h400 * 32'(level_q[1][7:ghr_pkg::HYST_LSB])))
        else $error("hysteresis decode wrong");

    // ************************************************************
    // output checks
    // ************************************************************
    en_gate_a: assert property (@(posedge clock) disable iff (!resetn) // R03
        !level_q[1][ghr_pkg::ALARM_EN_BIT] |=> !high_alarm[1])
        else $error("alarm output on a disabled axis");
    drift_gate_a: assert property ( // R08
        @(posedge clock) disable iff (!resetn)
        !drift_q[2] |=> !drift_step[2])
        else $error("drift step output on a disabled axis");
    step_sign_a: assert property ( // R13
        @(posedge clock) disable iff (!resetn)
        drift_step[0] |-> drift_step_neg[0] == $past(drift_src_unfilt ?
        rate_unfilt[0][15] : rate_filt[0][15]))
        else $error("drift step direction wrong");
    drift_src_a: assert property ( // R11
        @(posedge clock) disable iff (!resetn)
        drift_q[0] && drift_src_unfilt
        && ghr_pkg::magnitude(rate_unfilt[0]) >= ax_if[0].drift_level
        |=> !drift_step[0])
        else $error("drift step from the unselected source");
endmodule : ghr_top

// ==== sim/ghr_top_test.sv ====
// self-checking testbench for the gyro high-rate and drift cancel bank
`timescale 1ns/100ps
module ghr_top_test;
    // ****************
    // signals
    // ****************
    logic clock;
    logic resetn;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [2:0][15:0] rate_filt;
    logic [2:0][15:0] rate_unfilt;
    logic alarm_src_unfilt;
    logic drift_src_unfilt;
    logic [2:0] range_sel;
    logic [2:0] high_alarm;
    logic [2:0] drift_step;
    logic [2:0] drift_step_neg;
    int fails;
    int check_count;
    // bench model of the register file
    logic [7:0] mreg [logic [7:0]];
    int dlvl [4] = '{26, 52, 131, 262};

    // short ticks keep dwell and drift times within a short run
    ghr_top #(.ALARM_TICK_CYC(4), .DRIFT_TICK_CYC(4)) ghr_top_i (
        .clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rate_filt(rate_filt), .rate_unfilt(rate_unfilt),
        .alarm_src_unfilt(alarm_src_unfilt),
        .drift_src_unfilt(drift_src_unfilt), .range_sel(range_sel),
        .high_alarm(high_alarm), .drift_step(drift_step),
        .drift_step_neg(drift_step_neg));

    // ****************
    // tasks
    // ****************
    task automatic chk(input string nm, input logic [16:0] e,
                       input logic [16:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        if (mreg.exists(a)) mreg[a] = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = mreg.exists(a) ? mreg[a] : 8'h00;
        @(posedge clock);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        chk("reg_rdata", 17'(e), 17'(reg_rdata));
    endtask : rd

    task automatic set_rate(input int ax, input logic [15:0] v);
        rate_filt[ax] = v;
        rate_unfilt[ax] = v;
    endtask : set_rate

    // cycles until the alarm of an axis shows lvl; max+1 if never
    task automatic wait_alarm(input int ax, input logic lvl, input int max,
                              output int n);
        n = 0;
        while (high_alarm[ax] !== lvl && n <= max) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : wait_alarm

    // always advances first, so a pulse just seen is not counted again
    task automatic wait_step(input int ax, input int max, output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (drift_step[ax] !== 1'b1 && n < max);
    endtask : wait_step

    // ****************
    // clock, watchdog
    // ****************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        // the tests need about a thousand cycles; this allows twenty thousand
        #80000;
        fails++;
        end_sim();
    end

    // ****************
    // tests
    // ****************
    initial begin
        int n;
        int p;
        int lvl;
        logic [15:0] v;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        rate_filt = '0;
        rate_unfilt = '0;
        {alarm_src_unfilt, drift_src_unfilt} = 2'b00;
        range_sel = 3'h4;
        resetn = 1'b0;
        for (int ax = 0; ax < 3; ax++) begin
            mreg[8'h22 + 8'(2 * ax)] = {2'h0, 5'h01, 1'b0};
            mreg[8'h23 + 8'(2 * ax)] = 8'h19;
        end
        mreg[8'h31] = {2'h1, 3'h4, 3'h0};
        void'($urandom(32'h7c8a));
        repeat (4) @(posedge clock);
        #1;
        resetn = 1'b1;
        foreach (mreg[a]) rd(a);
        rd(8'h28);
        foreach (mreg[a]) wr(a, 8'($urandom));
        wr(8'h28, 8'h5a);
        foreach (mreg[a]) rd(a);
        rd(8'h28);
        foreach (mreg[a]) wr(a, 8'h00);
        for (int ax = 0; ax < 3; ax++) begin
            p = $urandom_range(3);
            v = 16'($urandom_range(32767, 2045));
            v = $urandom_range(1) ? v : -v;
            for (int k = 0; k < 3; k++) set_rate(k, v);
            wr(8'h23 + 8'(2 * ax), 8'(p));
            wr(8'h22 + 8'(2 * ax), {2'h0, 5'h01, 1'b1});
            wait_alarm(ax, 1'b1, 4 * p + 8, n);
            chk("alarm_dwell", 17'h1, 17'(n >= 4*p && n <= 4*p + 6));
            chk("alarm_other", 17'h0, 17'(high_alarm & ~(3'h1 << ax)));
            for (int k = 0; k < 3; k++) set_rate(k, 16'd1100);
            repeat (12) @(posedge clock);
            #1;
            chk("alarm_hold", 17'h1, 17'(high_alarm[ax]));
            for (int k = 0; k < 3; k++) set_rate(k, 16'd1000);
            wait_alarm(ax, 1'b0, 3, n);
            chk("alarm_clear", 17'h1, 17'(n <= 3));
            for (int k = 0; k < 3; k++) set_rate(k, v);
            wait_alarm(ax, 1'b1, 4 * p + 8, n);
            chk("alarm_again", 17'h1, 17'(n <= 4 * p + 8));
            wr(8'h22 + 8'(2 * ax), {2'h0, 5'h01, 1'b0});
            wait_alarm(ax, 1'b0, 3, n);
            chk("alarm_disable", 17'h1, 17'(n <= 3));
        end
        // hysteresis code 1 on z: level 4092, clear point 2048
        for (int k = 0; k < 3; k++) set_rate(k, 16'd4100);
        wr(8'h27, 8'h00);
        wr(8'h26, {2'h1, 5'h03, 1'b1});
        wait_alarm(2, 1'b1, 8, n);
        chk("hyst_set", 17'h1, 17'(n <= 8));
        for (int k = 0; k < 3; k++) set_rate(k, 16'd2100);
        repeat (12) @(posedge clock);
        #1;
        chk("hyst_hold", 17'h1, 17'(high_alarm[2]));
        for (int k = 0; k < 3; k++) set_rate(k, 16'd2040);
        wait_alarm(2, 1'b0, 3, n);
        chk("hyst_clear", 17'h1, 17'(n <= 3));
        wr(8'h26, 8'h00);
        for (int k = 0; k < 3; k++) set_rate(k, 16'h0000);
        rate_unfilt[0] = 16'd3000;
        wr(8'h23, 8'h00);
        wr(8'h22, {2'h0, 5'h00, 1'b1});
        wait_alarm(0, 1'b1, 16, n);
        chk("alarm_filtered", 17'h1, 17'(n > 16));
        alarm_src_unfilt = 1'b1;
        wait_alarm(0, 1'b1, 8, n);
        chk("alarm_unfiltered", 17'h1, 17'(n <= 8));
        wr(8'h22, 8'h00);
        // drift levels per code, last row at a coarser range
        for (int k = 0; k < 5; k++) begin
            range_sel = (k == 4) ? 3'h3 : 3'h4;
            lvl = dlvl[k == 4 ? 3 : k] >> (k == 4 ? 1 : 0);
            wr(8'h31, {2'(k == 4 ? 3 : k), 3'h0, 3'h1});
            set_rate(0, 16'(1 - lvl));
            set_rate(1, 16'h0003);
            wait_step(0, 12, n);
            chk("drift_step", 17'h1, 17'(drift_step[0]));
            chk("drift_neg", 17'h1, 17'(drift_step_neg[0]));
            chk("drift_other", 17'h0, 17'(drift_step[2:1]));
            set_rate(0, 16'(lvl));
            repeat (2) @(posedge clock);
            wait_step(0, 16, n);
            chk("drift_at_level", 17'h0, 17'(drift_step[0]));
        end
        range_sel = 3'h4;
        set_rate(0, 16'h0003);
        foreach (dlvl[t]) begin
            p = (t == 3) ? 6 : t;
            wr(8'h31, {2'h3, 3'(p), 3'h1});
            wait_step(0, 300, n);
            wait_step(0, 300, n);
            chk("drift_time", 17'(4 * (1 << (p > 5 ? 5 : p))), 17'(n));
            chk("drift_pos", 17'h0, 17'(drift_step_neg[0]));
        end
        wr(8'h31, {2'h3, 3'h0, 3'h1});
        rate_filt[0] = -16'sd5;
        rate_unfilt[0] = 16'd1000;
        drift_src_unfilt = 1'b1;
        repeat (2) @(posedge clock);
        wait_step(0, 16, n);
        chk("drift_unfilt", 17'h0, 17'(drift_step[0]));
        drift_src_unfilt = 1'b0;
        wait_step(0, 12, n);
        chk("drift_filt", 17'h1, 17'(drift_step[0]));
        end_sim();
    end
endmodule : ghr_top_test
